// *** pkg/lss_map.svh ***
/*
  constants of the segment shift and latch block: widths, depths, sync length
  and timing counts. assumes inclusion by bare name from package and modules.
*/
`ifndef LSS_MAP_SVH
`define LSS_MAP_SVH

`define LSS_HALF_BITS       20
`define LSS_ALL_BITS        40
`define LSS_SYNC_STAGES     3
`define LSS_FIFO_WIDTH      2
`define LSS_FIFO_DEPTH      4
`define LSS_CLK_PERIOD_NS   8
`define LSS_SETUP_NS        50
`define LSS_SETUP_CYC       ((`LSS_SETUP_NS + `LSS_CLK_PERIOD_NS - 1) / `LSS_CLK_PERIOD_NS)

`endif

// *** pkg/lss_pkg.sv ***
/*
  types of the segment shift and latch block.
  assumes lss_map.svh on the include path.
*/
`default_nettype none
`include "lss_map.svh"

package lss_pkg;

  // 2-bit drive-level code for the external analog switch stage
  typedef enum logic [1:0]
  {
    LSS_LVL_TOP        = 2'h0,
    LSS_LVL_TWO_THIRDS = 2'h1,
    LSS_LVL_ONE_THIRD  = 2'h3,
    LSS_LVL_LOWEST     = 2'h2
  } lss_level_t;

  // one fifo word: bit for each half, taken at the same shift edge
  typedef struct packed
  {
    logic bit_high;
    logic bit_low;
  } lss_pair_t;

  // pin inputs after the three-stage synchronisers
  typedef struct packed
  {
    logic [`LSS_SYNC_STAGES-1:0] clk_s;
    logic [`LSS_SYNC_STAGES-1:0] lo_s;
    logic [`LSS_SYNC_STAGES-1:0] hi_s;
    logic [`LSS_SYNC_STAGES-1:0] ld_s;
    logic [`LSS_SYNC_STAGES-1:0] df_s;
  } lss_sync_t;

  function automatic lss_level_t lss_level_of(input logic sel, input logic alt);
    lss_level_t lvl;
    lvl = LSS_LVL_TOP;
    if (sel && alt)
      lvl = LSS_LVL_LOWEST;
    else if (sel)
      lvl = LSS_LVL_TOP;
    else if (alt)
      lvl = LSS_LVL_ONE_THIRD;
    else
      lvl = LSS_LVL_TWO_THIRDS;
    return lvl;
  endfunction

endpackage

`default_nettype wire

// *** logic/lss_fifo.sv ***
/*
  small fifo with registered read data, valid and ready on both sides.
  assumes one clock and an active-low asynchronous reset.
*/
`default_nettype none
`include "lss_map.svh"

module lss_fifo #(
  parameter int WIDTH = `LSS_FIFO_WIDTH,
  parameter int DEPTH = `LSS_FIFO_DEPTH
) (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed
  {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wptr;
    logic [PW-1:0]               rptr;
    logic [PW:0]                 count;
    logic [WIDTH-1:0]            out_data;
    logic                        out_valid;
  } lss_fifo_state_t;

  lss_fifo_state_t st_r;
  lss_fifo_state_t st_nxt;
  logic            push;
  logic            pop;

  ////////////////////////////////////////////////////////////////////////////
  // storage full means no push; output register refills as soon as it drains
  assign in_ready  = (st_r.count != DEPTH[PW:0]);
  assign out_data  = st_r.out_data;
  assign out_valid = st_r.out_valid;

  always_comb
  begin
    st_nxt = st_r;
    push   = in_valid && in_ready;
    pop    = (st_r.count != '0) && (!st_r.out_valid || out_ready);
    if (push)
    begin
      st_nxt.mem[st_r.wptr] = in_data;
      st_nxt.wptr           = st_r.wptr + 1'b1;
    end
    if (pop)
    begin
      st_nxt.out_data  = st_r.mem[st_r.rptr];
      st_nxt.out_valid = 1'b1;
      st_nxt.rptr      = st_r.rptr + 1'b1;
    end
    else if (out_ready)
      st_nxt.out_valid = 1'b0;
    if (push && !pop)
      st_nxt.count = st_r.count + 1'b1;
    else if (pop && !push)
      st_nxt.count = st_r.count - 1'b1;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  count_bound_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    st_r.count <= DEPTH[PW:0])
    else $error("fifo count above depth");

endmodule

`default_nettype wire

// *** logic/lss_top.sv ***
/*
  serial-in, parallel-out segment data path: two 20-bit shift registers on
  the falling shift clock edge, a 40-bit level latch and a 2-bit drive code
  per output. assumes every pin input is asynchronous to ref_clk and far
  slower than it; shift events queue in a 4-word fifo before the registers.
*/
// Summary of operation
// [RULE_01] low-half input shifts positions 1 to 20
// [RULE_02] one shift clock advances both halves
// [RULE_03] data sampled on falling shift clock edge
// [RULE_04] low cascade output is stage 20
// [RULE_05] high cascade output is last high stage
// [RULE_06] looped cascade forms one 40-bit register
// [RULE_07] load high makes latch transparent
// [RULE_08] load low holds latched pattern
// [RULE_09] output order matches shift stage order
// [RULE_10] latched bit and alternation pick level
// [RULE_11] two-bit level code per output
// [RULE_12] each stage takes previous, stage one input
`default_nettype none
`include "lss_map.svh"

module lss_top
  import lss_pkg::*;
(
  input  wire logic                         ref_clk,
  input  wire logic                         reset_n,
  input  wire logic                         serial_in_low_half,
  input  wire logic                         serial_in_high_half,
  input  wire logic                         shift_clock,
  input  wire logic                         load,
  input  wire logic                         frame_alternation,
  output logic                              cascade_out_low_half,
  output logic                              cascade_out_high_half,
  output lss_level_t [`LSS_ALL_BITS-1:0]    segment_outputs,
  output logic                              overrun_flag
);

  typedef struct packed
  {
    lss_sync_t                          sync;
    logic                               clk_q;
    logic                               ld_q;
    logic                               df_q;
    logic [`LSS_HALF_BITS-1:0]          lo;
    logic [`LSS_HALF_BITS-1:0]          hi;
    logic [`LSS_ALL_BITS-1:0]           latch;
    lss_level_t [`LSS_ALL_BITS-1:0]     seg;
    logic                               overrun;
    logic                               pace;
  } lss_state_t;

  lss_state_t st_r;
  lss_state_t st_nxt;
  logic       shift_fire;
  lss_pair_t  push_pair;
  logic       push_ready;
  lss_pair_t  pop_pair;
  logic       pop_valid;
  logic       pop_ready;
  logic       pop_take;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: a clock, load or alternation change counts once stages two and three agree

  always_comb
  begin
    st_nxt            = st_r;
    st_nxt.sync.clk_s = {st_r.sync.clk_s[1:0], shift_clock};
    st_nxt.sync.lo_s  = {st_r.sync.lo_s[1:0], serial_in_low_half};
    st_nxt.sync.hi_s  = {st_r.sync.hi_s[1:0], serial_in_high_half};
    st_nxt.sync.ld_s  = {st_r.sync.ld_s[1:0], load};
    st_nxt.sync.df_s  = {st_r.sync.df_s[1:0], frame_alternation};
    if (st_r.sync.clk_s[1] == st_r.sync.clk_s[2])
      st_nxt.clk_q = st_r.sync.clk_s[2];
    if (st_r.sync.ld_s[1] == st_r.sync.ld_s[2])
      st_nxt.ld_q = st_r.sync.ld_s[2];
    if (st_r.sync.df_s[1] == st_r.sync.df_s[2])
      st_nxt.df_q = st_r.sync.df_s[2];

    // data travels through the same three stages as the clock, so the bit
    // seen at the detected edge is the one that met set-up and hold
    shift_fire         = st_r.clk_q && (st_r.sync.clk_s[1] == 1'b0)
                         && (st_r.sync.clk_s[2] == 1'b0); // RULE_03
    push_pair.bit_low  = st_r.sync.lo_s[2]; // RULE_01
    push_pair.bit_high = st_r.sync.hi_s[2];

    // a full queue can only follow a shift clock far above the rated rate
    if (shift_fire && !push_ready)
      st_nxt.overrun = 1'b1;

    // drain paced at half rate; stalls the fifo so bursts really queue up
    st_nxt.pace = !st_r.pace;
    pop_ready   = st_r.pace;
    pop_take    = pop_valid && pop_ready;

    ////////////////////////////////////////////////////////////////////////////
    // shift registers: one queued edge advances both halves together
    if (pop_take)
    begin
      st_nxt.lo = {st_r.lo[`LSS_HALF_BITS-2:0], pop_pair.bit_low}; // RULE_02 RULE_12
      st_nxt.hi = {st_r.hi[`LSS_HALF_BITS-2:0], pop_pair.bit_high}; // RULE_02 RULE_12
    end

    ////////////////////////////////////////////////////////////////////////////
    // level latch: follows the registers while load is high, else holds
    if (st_r.ld_q)
      st_nxt.latch = {st_r.hi, st_r.lo}; // RULE_07 RULE_09
    // load low keeps the latch untouched by shifting // RULE_08

    for (int k = 0; k < `LSS_ALL_BITS; k++)
      st_nxt.seg[k] = lss_level_of(st_r.latch[k], st_r.df_q); // RULE_10 RULE_11
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // edge queue

  lss_fifo #(
    .WIDTH (`LSS_FIFO_WIDTH),
    .DEPTH (`LSS_FIFO_DEPTH)
  ) u_edge_fifo (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .in_data   (push_pair),
    .in_valid  (shift_fire),
    .in_ready  (push_ready),
    .out_data  (pop_pair),
    .out_valid (pop_valid),
    .out_ready (pop_ready)
  );

  // when the low cascade is wired to the high input the halves chain into one
  // 40-bit register, stage 20 feeding stage 21 on the same edge // RULE_06
  assign cascade_out_low_half  = st_r.lo[`LSS_HALF_BITS-1]; // RULE_04
  assign cascade_out_high_half = st_r.hi[`LSS_HALF_BITS-1]; // RULE_05
  assign segment_outputs       = st_r.seg;
  assign overrun_flag          = st_r.overrun;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  low_entry_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE_01
    pop_take |=> st_r.lo[0] == $past(pop_pair.bit_low))
    else $error("low half stage one missed the input bit");

  both_advance_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE_02
    pop_take |=> (st_r.hi[`LSS_HALF_BITS-1:1] == $past(st_r.hi[`LSS_HALF_BITS-2:0]))
      && (st_r.lo[`LSS_HALF_BITS-1:1] == $past(st_r.lo[`LSS_HALF_BITS-2:0])))
    else $error("halves did not advance together");

  fall_edge_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE_03
    shift_fire |=> !st_r.clk_q ##1 !shift_fire)
    else $error("shift taken on something other than a falling edge");

  low_cascade_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE_04
    pop_take |=> cascade_out_low_half == $past(st_r.lo[`LSS_HALF_BITS-2]))
    else $error("low cascade not fed from stage 19");

  high_cascade_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE_05
    !pop_take |=> $stable(cascade_out_high_half))
    else $error("high cascade moved without a shift");

  transparent_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE_07
    st_r.ld_q |=> st_r.latch == $past({st_r.hi, st_r.lo}))
    else $error("latch not transparent with load high");

  hold_latch_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE_08
    !st_r.ld_q ##1 (!st_r.ld_q && $stable(st_r.df_q))
      |=> $stable(st_r.latch) && $stable(segment_outputs[7]))
    else $error("latch changed with load low");

  level_map_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE_10
    $past(reset_n) |->
      segment_outputs[0] == lss_level_of($past(st_r.latch[0]), $past(st_r.df_q)))
    else $error("first output level wrong");

  order_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE_09
    st_r.ld_q ##1 st_r.ld_q |=> (segment_outputs[39] == lss_level_of(
      $past(st_r.hi[`LSS_HALF_BITS-1], 2), $past(st_r.df_q)))
      && (segment_outputs[20] == lss_level_of($past(st_r.hi[0], 2), $past(st_r.df_q))))
    else $error("output order differs from stage order");

  code_map_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE_11
    (st_r.latch[5] && !st_r.df_q) |=> segment_outputs[5] == LSS_LVL_TOP)
    else $error("selected with alternation low is not top level");

endmodule

`default_nettype wire

// *** verification/lss_ctrl_model.sv ***
/*
  behavioural lcd controller: serial data, shift clock, load, alternation.
  assumes a 125 MHz ref_clk and one caller at a time.
*/
`default_nettype none

module lss_ctrl_model
(
  input  wire logic ref_clk,
  input  wire logic cascade_out_low_half,
  output logic      serial_in_low_half,
  output logic      serial_in_high_half,
  output logic      shift_clock,
  output logic      load,
  output logic      frame_alternation
);
  timeunit 1ns;
  timeprecision 100ps;

  logic lo_r;
  logic hi_r;
  logic loop_r;

  initial
  begin
    lo_r = 1'b0;
    hi_r = 1'b0;
    loop_r = 1'b0;
    shift_clock = 1'b0;
    load = 1'b0;
    frame_alternation = 1'b0;
  end

  assign serial_in_low_half = lo_r;
  // old stage 20 is sampled before it moves, so the loop chains cleanly
  assign serial_in_high_half = loop_r ? cascade_out_low_half : hi_r;

  ////////////////////////////////////////////////////////////////////////////
  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic shift_pair(input logic lo, input logic hi);
    lo_r = lo;
    hi_r = hi;
    shift_clock = 1'b1;
    cycles(16);
    shift_clock = 1'b0;
    cycles(8);
    // stale data flips after the hold so a late sample shows up
    lo_r = ~lo;
    hi_r = ~hi;
    cycles(8);
  endtask

  // long wait first: shift to load set-up is 50 ns
  task automatic set_load(input logic v);
    cycles(32);
    load = v;
    cycles(16);
  endtask

  task automatic set_alt(input logic v);
    frame_alternation = v;
    cycles(8);
  endtask

  task automatic set_loop(input logic v);
    loop_r = v;
  endtask
endmodule

`default_nettype wire

// *** verification/lss_top_tb.sv ***
/*
  bench for lss_top driven by the controller model, with a mid-run reset.
  assumes lss_pkg and lss_map.svh compiled and on the include path.
*/
`default_nettype none

module lss_top_tb
  import lss_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [19:0] PAT_LO = 20'h9C35A;
  localparam logic [19:0] PAT_HI = 20'hE1A96;
  localparam logic [39:0] PAT_40 = 40'hC35A96E12B;

  logic              ref_clk;
  logic              reset_n;
  logic              s_lo;
  logic              s_hi;
  logic              s_clk;
  logic              s_ld;
  logic              s_alt;
  logic              c_lo;
  logic              c_hi;
  lss_level_t [39:0] segment_outputs;
  logic              overrun_flag;
  int                err_total;
  int                num_checks;

  lss_ctrl_model u_lss_ctrl_model
  (
    .ref_clk(ref_clk), .cascade_out_low_half(c_lo), .serial_in_low_half(s_lo),
    .serial_in_high_half(s_hi), .shift_clock(s_clk), .load(s_ld),
    .frame_alternation(s_alt)
  );

  lss_top u_lss_top
  (
    .ref_clk(ref_clk), .reset_n(reset_n), .serial_in_low_half(s_lo),
    .serial_in_high_half(s_hi), .shift_clock(s_clk), .load(s_ld),
    .frame_alternation(s_alt), .cascade_out_low_half(c_lo),
    .cascade_out_high_half(c_hi), .segment_outputs(segment_outputs),
    .overrun_flag(overrun_flag)
  );

  always #4 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (err_total == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic bad(input string what);
    err_total++;
    $display("BAD %0t %s", $time, what);
  endtask

  task automatic chk(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp)
      bad(what);
  endtask

  task automatic check_segs(input logic [39:0] b, input logic alt, input string what);
    lss_level_t [39:0] exp;
    for (int k = 0; k < 40; k++)
      exp[k] = b[k] ? (alt ? LSS_LVL_LOWEST : LSS_LVL_TOP)
                    : (alt ? LSS_LVL_ONE_THIRD : LSS_LVL_TWO_THIRDS);
    num_checks++;
    if (segment_outputs !== exp)
      bad(what);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // cascades must still show reset zeros after 19 edges: delay is exactly 20
  task automatic run_split();
    check_segs(40'h0, 1'b0, "idle latch");
    for (int i = 19; i > 0; i--)
      u_lss_ctrl_model.shift_pair(PAT_LO[i], PAT_HI[i]);
    chk(c_lo, 1'b0, "low cascade early");
    chk(c_hi, 1'b0, "high cascade early");
    u_lss_ctrl_model.shift_pair(PAT_LO[0], PAT_HI[0]);
    chk(c_lo, PAT_LO[19], "low cascade");
    chk(c_hi, PAT_HI[19], "high cascade");
    u_lss_ctrl_model.set_load(1'b1);
    u_lss_ctrl_model.set_load(1'b0);
    check_segs({PAT_HI, PAT_LO}, 1'b0, "split load");
  endtask

  task automatic run_hold();
    for (int i = 19; i >= 0; i--)
      u_lss_ctrl_model.shift_pair(~PAT_LO[i], ~PAT_HI[i]);
    check_segs({PAT_HI, PAT_LO}, 1'b0, "held");
    u_lss_ctrl_model.set_load(1'b1);
    u_lss_ctrl_model.set_load(1'b0);
    u_lss_ctrl_model.set_alt(1'b1);
    check_segs(~{PAT_HI, PAT_LO}, 1'b1, "alt high");
    u_lss_ctrl_model.set_alt(1'b0);
    check_segs(~{PAT_HI, PAT_LO}, 1'b0, "alt low");
  endtask

  // transparent latch shows the chain while it is still moving
  task automatic run_chain();
    u_lss_ctrl_model.set_loop(1'b1);
    u_lss_ctrl_model.set_load(1'b1);
    for (int i = 39; i > 0; i--)
      u_lss_ctrl_model.shift_pair(PAT_40[i], 1'b0);
    check_segs({~PAT_LO[0], PAT_40[39:1]}, 1'b0, "chain 39");
    u_lss_ctrl_model.shift_pair(PAT_40[0], 1'b0);
    check_segs(PAT_40, 1'b0, "chain 40");
    chk(c_hi, PAT_40[39], "chain cascade");
    u_lss_ctrl_model.set_load(1'b0);
    u_lss_ctrl_model.shift_pair(1'b1, 1'b0);
    check_segs(PAT_40, 1'b0, "chain held");
    u_lss_ctrl_model.set_loop(1'b0);
    chk(overrun_flag, 1'b0, "overrun");
  endtask

  // mid-run reset with load high: outputs clear, then the queue path works again
  task automatic run_reset();
    u_lss_ctrl_model.set_load(1'b1);
    check_segs({PAT_40[38:0], 1'b1}, 1'b0, "before reset");
    reset_n = 1'b0;
    u_lss_ctrl_model.cycles(2);
    check_segs({40{1'b1}}, 1'b0, "reset codes");
    chk(c_lo, 1'b0, "reset low cascade");
    chk(c_hi, 1'b0, "reset high cascade");
    reset_n = 1'b1;
    u_lss_ctrl_model.cycles(8);
    check_segs(40'h0, 1'b0, "after reset");
    u_lss_ctrl_model.shift_pair(1'b1, 1'b1);
    check_segs({20'h00001, 20'h00001}, 1'b0, "shift after reset");
    u_lss_ctrl_model.set_load(1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 1'b0;
    reset_n = 1'b0;
    err_total = 0;
    num_checks = 0;
    repeat (3) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    u_lss_ctrl_model.cycles(8);
    run_split();
    run_hold();
    run_chain();
    run_reset();
    complete_run();
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    bad("timeout");
    complete_run();
  end
endmodule

`default_nettype wire
